// File: core/ccf_pkg.sv
// Package of constants and carrier types for the capture/compare status flag block.
package ccf_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_GR = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_MODE      = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_EDGE      = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_GR_A      = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_GR_B      = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_GR_C      = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_GR_D      = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_COUNT     = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 4'hA;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_FLAG_A   = 0;
  localparam int BIT_FLAG_B   = 1;
  localparam int BIT_FLAG_C   = 2;
  localparam int BIT_FLAG_D   = 3;
  localparam int EVT_SET_LSB  = 0;
  localparam int EVT_OVR_LSB  = 4;
  localparam int EDGE_FIELD_W = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [NUM_GR-1:0]   RST_FLAGS    = 4'h0;
  localparam logic [NUM_GR-1:0]   RST_IRQ_EN   = 4'h0;
  localparam logic [NUM_GR-1:0]   RST_MODE     = 4'h0;
  localparam logic [7:0]          RST_EDGE     = 8'h00;
  localparam logic [DATA_W-1:0]   RST_GR       = 16'h0000;
  localparam logic [7:0]          RST_EVT_STAT = 8'h00;
  localparam logic [7:0]          RST_EVT_MASK = 8'h00;
  localparam logic [DATA_W-1:0]   READ_ZERO    = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } cap_edge_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic [NUM_GR-1:0] start;
    logic [NUM_GR-1:0] transfer_end_irq_select;
    logic [NUM_GR-1:0] count_nz;
  } xfer_req_s;

endpackage

// File: core/match_detect.sv
// Compare-match and input-capture event detector for one general register.
`timescale 1ns/1ps
module match_detect #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Operands
  input  wire logic [DATA_W-1:0] counter,
  input  wire logic [DATA_W-1:0] compare_val,
  input  wire logic              capture_mode,
  input  wire logic [1:0]        edge_sel,
  input  wire logic              capture_pin,
  // Events
  output logic                   set_pulse,
  output logic                   load_pulse
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic eq_prev_q;
  logic eq;
  logic rise;
  logic fall;
  logic cap_hit;

  // The pin is asynchronous; only the second and third stages feed the edge logic.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= capture_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Equality is edge-detected so a stopped counter yields one match, not a stream.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      eq_prev_q <= 1'b1;
    end else if (clk_en) begin
      eq_prev_q <= eq;
    end
  end

  assign eq   = (counter == compare_val);
  assign rise = sync2_q & ~sync3_q;
  assign fall = ~sync2_q & sync3_q;

  always_comb begin
    case (edge_sel)
      ccf_pkg::EDGE_RISE: cap_hit = rise;
      ccf_pkg::EDGE_FALL: cap_hit = fall;
      default:            cap_hit = rise | fall;
    endcase
  end

  assign load_pulse = clk_en & capture_mode & cap_hit;
  assign set_pulse  = load_pulse | (clk_en & ~capture_mode & eq & ~eq_prev_q);

endmodule

// File: core/flag_cell.sv
// One sticky status flag with read-then-write-zero and automatic transfer clearing.
`timescale 1ns/1ps
module flag_cell (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Control
  input  wire logic present,
  input  wire logic set_evt,
  input  wire logic read_seen,
  input  wire logic sw_write,
  input  wire logic sw_bit,
  input  wire logic auto_clr,
  // State
  output logic      flag
);

  logic flag_q;
  logic armed_q;

  // A set in the same cycle as either clear keeps the flag high.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (!present) begin
        flag_q <= 1'b0;
      end else if (set_evt) begin
        flag_q <= 1'b1;
      end else if ((sw_write && !sw_bit && armed_q) || auto_clr) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Arming remembers that software has seen this flag as one.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (read_seen && flag_q) begin
        armed_q <= 1'b1;
      end else if (sw_write || !flag_q) begin
        armed_q <= 1'b0;
      end
    end
  end

  assign flag = flag_q;

endmodule

// File: core/capture_compare_status_flags.sv
// Capture/compare status flags of one timer channel with register port and interrupt.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// Summary of operation
// - Flag A sets on counter match with register A, or capture into A.
// - Flag B sets on counter match with register B, or capture into B.
// - On channels 0 and 3, flag C sets on match or capture of C.
// - On channels 0 and 3, flag D sets on match or capture of D.
// - Other channels read flags C and D as zero and ignore writes.
// - A started transfer with select zero and nonzero count clears its flag.
// - Software clears a flag only by reading one, then writing zero.
// - Writing one to a flag leaves it set but ends the arming from the last read.
// - All four flags are zero after reset.
// - Each request is high only while its flag and enable are both one.
module capture_compare_status_flags #(
  parameter int CHANNEL_ID = 0,
  parameter int DATA_W     = 16
) (
  // Clock, reset and clock enable
  input  wire logic                         CLOCK,
  input  wire logic                         SYS_RST,
  input  wire logic                         CLK_EN,
  // Register port
  input  wire logic [ccf_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [DATA_W-1:0]            WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [DATA_W-1:0]            RDATA,
  // Counter and capture pins
  input  wire logic [DATA_W-1:0]            CHANNEL_COUNTER,
  input  wire logic [ccf_pkg::NUM_GR-1:0]   CAPTURE_PIN,
  // Transfer controller
  input  wire ccf_pkg::xfer_req_s           XFER,
  // Requests and interrupt
  output logic      [ccf_pkg::NUM_GR-1:0]   COMPARE_IRQ,
  output logic      [ccf_pkg::NUM_GR-1:0]   MATCH_FLAGS,
  output logic                              IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic HAS_CD = (CHANNEL_ID == 0) || (CHANNEL_ID == 3);
  localparam int   N      = ccf_pkg::NUM_GR;

  ccf_pkg::reg_req_s req;

  logic [N-1:0]        present;
  logic [N-1:0]        flags;
  logic [N-1:0]        set_evt;
  logic [N-1:0]        load_evt;
  logic [N-1:0]        auto_clr;
  logic [N-1:0]        irq_en_q;
  logic [N-1:0]        mode_q;
  logic [7:0]          edge_q;
  logic [DATA_W-1:0]   gr_q [N];
  logic [7:0]          evt_stat_q;
  logic [7:0]          evt_mask_q;
  logic [7:0]          evt_new;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic                wr_flags;
  logic                rd_flags;
  logic                wr_irq_en;
  logic                wr_mode;
  logic                wr_edge;
  logic                wr_evt_stat;
  logic                wr_evt_mask;

  // ----------------------------------------------------------------
  // Bus request and decode
  // ----------------------------------------------------------------
  assign req.addr  = ADDR;
  assign req.wdata = WDATA;
  assign req.wr    = WR & CLK_EN;
  assign req.rd    = RD & CLK_EN;

  assign wr_flags    = req.wr && (req.addr == ccf_pkg::OFS_FLAGS);
  assign rd_flags    = req.rd && (req.addr == ccf_pkg::OFS_FLAGS);
  assign wr_irq_en   = req.wr && (req.addr == ccf_pkg::OFS_IRQ_EN);
  assign wr_mode     = req.wr && (req.addr == ccf_pkg::OFS_MODE);
  assign wr_edge     = req.wr && (req.addr == ccf_pkg::OFS_EDGE);
  assign wr_evt_stat = req.wr && (req.addr == ccf_pkg::OFS_EVT_STAT);
  assign wr_evt_mask = req.wr && (req.addr == ccf_pkg::OFS_EVT_MASK);

  // Registers C and D exist only on the channels that carry them.
  assign present = {HAS_CD, HAS_CD, 1'b1, 1'b1};

  // ----------------------------------------------------------------
  // Per-register event detection and flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_gr
      logic [ccf_pkg::EDGE_FIELD_W-1:0] edge_sel;
      logic                             set_raw;
      logic                             load_raw;

      assign edge_sel = edge_q[g*ccf_pkg::EDGE_FIELD_W +: ccf_pkg::EDGE_FIELD_W];

      match_detect #(
        .DATA_W (DATA_W)
      ) u_detect (
        .clock        (CLOCK),
        .sys_rst      (SYS_RST),
        .clk_en       (CLK_EN),
        .counter      (CHANNEL_COUNTER),
        .compare_val  (gr_q[g]),
        .capture_mode (mode_q[g]),
        .edge_sel     (edge_sel),
        .capture_pin  (CAPTURE_PIN[g]),
        .set_pulse    (set_raw),
        .load_pulse   (load_raw)
      );

      // Match or capture sets the flag of A, B and, where present, C and D.
      assign set_evt[g]  = set_raw & present[g];
      assign load_evt[g] = load_raw & present[g];

      // A started transfer clears only when the end select is zero and work remains.
      assign auto_clr[g] = XFER.start[g] & ~XFER.transfer_end_irq_select[g] & XFER.count_nz[g];

      flag_cell u_flag (
        .clock     (CLOCK),
        .sys_rst   (SYS_RST),
        .clk_en    (CLK_EN),
        .present   (present[g]),
        .set_evt   (set_evt[g]),
        .read_seen (rd_flags),
        .sw_write  (wr_flags),
        .sw_bit    (req.wdata[g]),
        .auto_clr  (auto_clr[g]),
        .flag      (flags[g])
      );

      // Capture takes precedence over a software write in the same cycle.
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          gr_q[g] <= ccf_pkg::RST_GR;
        end else if (CLK_EN) begin
          if (load_evt[g]) begin
            gr_q[g] <= CHANNEL_COUNTER;
          end else if (req.wr && present[g] &&
                       (req.addr == ccf_pkg::OFS_GR_A + ccf_pkg::ADDR_W'(g))) begin
            gr_q[g] <= req.wdata;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_en_q <= ccf_pkg::RST_IRQ_EN;
    end else if (wr_irq_en) begin
      irq_en_q <= req.wdata[N-1:0] & present;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mode_q <= ccf_pkg::RST_MODE;
    end else if (wr_mode) begin
      mode_q <= req.wdata[N-1:0] & present;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      edge_q <= ccf_pkg::RST_EDGE;
    end else if (wr_edge) begin
      edge_q <= req.wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transfer requests
  // ----------------------------------------------------------------
  // Requests follow the flag with no added latency so the transfer
  // controller sees the same state that software would read.
  assign COMPARE_IRQ = flags & irq_en_q;
  assign MATCH_FLAGS = flags;

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  // Low half records each set; high half records a set that found its
  // flag still high, meaning the earlier event was never serviced.
  assign evt_new[ccf_pkg::EVT_SET_LSB +: N] = set_evt;
  assign evt_new[ccf_pkg::EVT_OVR_LSB +: N] = set_evt & flags;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      evt_stat_q <= ccf_pkg::RST_EVT_STAT;
    end else if (CLK_EN) begin
      if (wr_evt_stat) begin
        evt_stat_q <= (evt_stat_q & ~req.wdata[7:0]) | evt_new;
      end else begin
        evt_stat_q <= evt_stat_q | evt_new;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      evt_mask_q <= ccf_pkg::RST_EVT_MASK;
    end else if (wr_evt_mask) begin
      evt_mask_q <= req.wdata[7:0];
    end
  end

  assign IRQ = |(evt_stat_q & evt_mask_q);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = ccf_pkg::READ_ZERO;
    case (req.addr)
      ccf_pkg::OFS_FLAGS:    rdata_d[N-1:0] = flags & present;
      ccf_pkg::OFS_IRQ_EN:   rdata_d[N-1:0] = irq_en_q;
      ccf_pkg::OFS_MODE:     rdata_d[N-1:0] = mode_q;
      ccf_pkg::OFS_EDGE:     rdata_d[7:0]   = edge_q;
      ccf_pkg::OFS_GR_A:     rdata_d        = gr_q[0];
      ccf_pkg::OFS_GR_B:     rdata_d        = gr_q[1];
      ccf_pkg::OFS_GR_C:     rdata_d        = present[2] ? gr_q[2] : ccf_pkg::READ_ZERO;
      ccf_pkg::OFS_GR_D:     rdata_d        = present[3] ? gr_q[3] : ccf_pkg::READ_ZERO;
      ccf_pkg::OFS_COUNT:    rdata_d        = CHANNEL_COUNTER;
      ccf_pkg::OFS_EVT_STAT: rdata_d[7:0]   = evt_stat_q;
      ccf_pkg::OFS_EVT_MASK: rdata_d[7:0]   = evt_mask_q;
      default:               rdata_d        = ccf_pkg::READ_ZERO;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= ccf_pkg::READ_ZERO;
    end else if (CLK_EN) begin
      rdata_q <= req.rd ? rdata_d : ccf_pkg::READ_ZERO;
    end
  end

  assign RDATA = rdata_q;

endmodule

// File: dv/capture_compare_status_flags_asserts.sv
// Checker of flag, request and register port behaviour of one timer channel.
`timescale 1ns/1ps
module capture_compare_status_flags_asserts #(
  parameter int CHANNEL_ID = 0,
  parameter int DATA_W     = 16
) (
  // Clock and reset
  input wire logic                       CLOCK,
  input wire logic                       SYS_RST,
  input wire logic                       CLK_EN,
  // Register port
  input wire logic [ccf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0]          WDATA,
  input wire logic                       WR,
  input wire logic                       RD,
  input wire logic [DATA_W-1:0]          RDATA,
  // Counter, pins and transfer controller
  input wire logic [DATA_W-1:0]          CHANNEL_COUNTER,
  input wire logic [ccf_pkg::NUM_GR-1:0] CAPTURE_PIN,
  input wire ccf_pkg::xfer_req_s         XFER,
  // Outputs
  input wire logic [ccf_pkg::NUM_GR-1:0] COMPARE_IRQ,
  input wire logic [ccf_pkg::NUM_GR-1:0] MATCH_FLAGS,
  input wire logic                       IRQ
);
  logic [3:0] armed_q;
  logic [3:0] may_clr;
  wire        fl_rd = RD && ADDR == ccf_pkg::OFS_FLAGS;
  wire        fl_wr = WR && ADDR == ccf_pkg::OFS_FLAGS;

  // A read only widens the set of bits that may fall, so this model can never be stricter than the design.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      armed_q <= 4'h0;
    end else if (CLK_EN && fl_rd) begin
      armed_q <= armed_q | MATCH_FLAGS;
    end else if (CLK_EN && fl_wr) begin
      armed_q <= 4'h0;
    end
  end
  assign may_clr = (fl_wr ? armed_q & ~WDATA[3:0] : 4'h0) | (XFER.start & ~XFER.transfer_end_irq_select & XFER.count_nz);

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_reset_zero: assert property (disable iff (1'b0) SYS_RST |=>
    MATCH_FLAGS == 4'h0 && COMPARE_IRQ == 4'h0 && RDATA == '0) else $error("flags not zero after reset");
  a_rdata_idle: assert property (CLK_EN && !RD |=> RDATA == '0)
    else $error("read data not zero outside a read");
  a_flag_readback: assert property (CLK_EN && fl_rd |=> RDATA == DATA_W'($past(MATCH_FLAGS)))
    else $error("flag read returns wrong value");
  a_unmapped_zero: assert property (CLK_EN && RD && ADDR > ccf_pkg::OFS_EVT_MASK |=> RDATA == '0)
    else $error("unmapped read not zero");
  a_cd_absent: assert property (CHANNEL_ID != 0 && CHANNEL_ID != 3 |-> MATCH_FLAGS[3:2] == 2'b00)
    else $error("absent flag bits not zero");
  a_irq_gate: assert property ((COMPARE_IRQ & ~MATCH_FLAGS) == 4'h0)
    else $error("request without its flag");
  a_no_stray_clr: assert property (CLK_EN |=> ($past(MATCH_FLAGS) & ~MATCH_FLAGS & ~$past(may_clr)) == 4'h0)
    else $error("flag cleared without a legal clear");
  a_freeze_hold: assert property (!CLK_EN |=> $stable(MATCH_FLAGS) && $stable(RDATA))
    else $error("state moved while the clock enable was low");
endmodule

bind capture_compare_status_flags capture_compare_status_flags_asserts #(
  .CHANNEL_ID(CHANNEL_ID), .DATA_W(DATA_W)
) chk_u (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CHANNEL_COUNTER(CHANNEL_COUNTER), .CAPTURE_PIN(CAPTURE_PIN), .XFER(XFER),
  .COMPARE_IRQ(COMPARE_IRQ), .MATCH_FLAGS(MATCH_FLAGS), .IRQ(IRQ));

// File: dv/xfer_ctrl_model.sv
// Behavioural transfer controller that starts on a rising flag request.
`timescale 1ns/1ps
module xfer_ctrl_model (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Set-up from the bench
  input  wire logic [3:0]   enable,
  input  wire logic [3:0]   end_sel,
  input  wire logic [3:0]   count_nz,
  input  wire logic         slow,
  // Requests and transfer start
  input  wire logic [3:0]   irq,
  output ccf_pkg::xfer_req_s xfer
);
  logic [3:0] irq_q;
  logic [3:0] pipe_q [4];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_q <= 4'h0;
      pipe_q <= '{default: 4'h0};
    end else begin
      irq_q <= irq;
      pipe_q[0] <= irq & ~irq_q & enable;
      for (int i = 1; i < 4; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end
  // A slow answer lets the request stand several cycles before the start.
  assign xfer.start    = slow ? pipe_q[3] : pipe_q[0];
  assign xfer.transfer_end_irq_select    = end_sel;
  assign xfer.count_nz = count_nz;
endmodule

// File: dv/capture_compare_status_flags_tb.sv
// Self-checking bench of the capture/compare status flag block.
`timescale 1ns/1ps
module capture_compare_status_flags_tb;
  logic               clock = 1'b0;
  logic               sys_rst = 1'b1;
  logic               clk_en = 1'b1;
  logic [3:0]         addr = 4'h0;
  logic [15:0]        wdata = 16'h0000;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [15:0]        cnt = 16'h0000;
  logic [3:0]         cap = 4'h0;
  logic [3:0]         x_en = 4'h0;
  logic [3:0]         x_sel = 4'h0;
  logic [3:0]         x_nz = 4'h0;
  logic               slow = 1'b0;
  logic [15:0]        rdata;
  logic [3:0]         req;
  logic [3:0]         flags;
  logic [3:0]         alt_flags;
  logic               irq;
  ccf_pkg::xfer_req_s xfer;
  logic [15:0]        d;
  int                 n_fail = 0;
  int                 n_compared = 0;

  always #2 clock = ~clock;

  capture_compare_status_flags #(.CHANNEL_ID(0)) dut_u (
    .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CHANNEL_COUNTER(cnt), .CAPTURE_PIN(cap), .XFER(xfer), .COMPARE_IRQ(req),
    .MATCH_FLAGS(flags), .IRQ(irq));
  capture_compare_status_flags #(.CHANNEL_ID(1)) alt_u (
    .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(), .CHANNEL_COUNTER(cnt), .CAPTURE_PIN(cap), .XFER(xfer), .COMPARE_IRQ(),
    .MATCH_FLAGS(alt_flags), .IRQ());
  xfer_ctrl_model xfer_u (
    .clock(clock), .sys_rst(sys_rst), .enable(x_en), .end_sel(x_sel), .count_nz(x_nz), .slow(slow),
    .irq(req), .xfer(xfer));

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_compare();
    rd_reg(ccf_pkg::OFS_FLAGS, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ccf_pkg::OFS_GR_A + 4'(i), 16'h0040 + 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      cnt <= 16'h0040 + 16'(i);
      @(posedge clock);
      #1;
      chk(16'(flags), 16'((1 << (i + 1)) - 1));
    end
    chk(16'(alt_flags), 16'h0003);
    chk(16'(req), 16'h0000);
    rd_reg(ccf_pkg::OFS_EVT_STAT, d);
    chk(d, 16'h000F);
  endtask

  task automatic t_clear();
    rd_reg(ccf_pkg::OFS_FLAGS, d);
    wr_reg(ccf_pkg::OFS_FLAGS, 16'h000F);
    chk(16'(flags), 16'h000F);
    wr_reg(ccf_pkg::OFS_FLAGS, 16'h0000);
    chk(16'(flags), 16'h000F);
    rd_reg(ccf_pkg::OFS_FLAGS, d);
    wr_reg(ccf_pkg::OFS_FLAGS, 16'h000C);
    chk(16'(flags), 16'h000C);
    rd_reg(ccf_pkg::OFS_FLAGS, d);
    wr_reg(ccf_pkg::OFS_FLAGS, 16'h0000);
    chk(16'(flags), 16'h0000);
    rd_reg(4'hF, d);
    chk(d, 16'h0000);
  endtask

  task automatic t_interrupt();
    chk(16'(irq), 16'h0000);
    wr_reg(ccf_pkg::OFS_EVT_MASK, 16'h0001);
    chk(16'(irq), 16'h0001);
    wr_reg(ccf_pkg::OFS_EVT_STAT, 16'h000F);
    chk(16'(irq), 16'h0000);
    wr_reg(ccf_pkg::OFS_EVT_MASK, 16'h0000);
  endtask

  // Each pass arms the transfer model differently; only select zero with a nonzero count may clear.
  task automatic t_auto();
    wr_reg(ccf_pkg::OFS_IRQ_EN, 16'h0001);
    x_en <= 4'h1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      x_sel <= {3'b000, k == 1};
      x_nz <= {3'b000, k != 2};
      slow <= (k == 0);
      cnt <= 16'h0000;
      @(posedge clock);
      cnt <= 16'h0040;
      @(posedge clock);
      #1;
      chk(16'(req), 16'h0001);
      repeat (8) @(posedge clock);
      #1;
      chk(16'(flags[0]), 16'(k != 0));
      rd_reg(ccf_pkg::OFS_FLAGS, d);
      wr_reg(ccf_pkg::OFS_FLAGS, 16'h0000);
      chk(16'(req), 16'h0000);
    end
  endtask

  task automatic t_capture();
    wr_reg(ccf_pkg::OFS_MODE, 16'h0001);
    @(posedge clock);
    cnt <= 16'h1234;
    cap <= 4'h1;
    clk_en <= 1'b0;
    @(posedge clock);
    clk_en <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk(16'(flags[0]), 16'h0001);
    rd_reg(ccf_pkg::OFS_GR_A, d);
    chk(d, 16'h1234);
    wr_reg(ccf_pkg::OFS_EDGE, 16'h0001);
    @(posedge clock);
    cnt <= 16'h5678;
    cap <= 4'h0;
    repeat (4) @(posedge clock);
    #1;
    rd_reg(ccf_pkg::OFS_GR_A, d);
    chk(d, 16'h5678);
    rd_reg(ccf_pkg::OFS_EVT_STAT, d);
    chk(d, 16'h0011);
    rd_reg(ccf_pkg::OFS_COUNT, d);
    chk(d, 16'h5678);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_compare();
    t_clear();
    t_interrupt();
    t_auto();
    t_capture();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    stop_test();
  end
endmodule
